// ==== design/rox_pkg.sv ====
// package of constants and types for the registered octal bus transceiver
package rox_pkg;
   // ------------------------------------------------------------
   // widths and depths
   // ------------------------------------------------------------
   localparam int ROX_DATA_W = 8;
   localparam int ROX_LOG_DEPTH = 16;
   localparam int ROX_LOG_W = ROX_DATA_W + 1;
   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] ROX_STORE_RST = 8'h00;
   localparam logic ROX_CLK_PREV_RST = 1'h1;
   // ------------------------------------------------------------
   // capture log record layout
   // ------------------------------------------------------------
   localparam int ROX_LOG_SIDE_BIT = 8;
   localparam logic ROX_SIDE_A = 1'h0;
   localparam logic ROX_SIDE_B = 1'h1;
   // ------------------------------------------------------------
   // bus modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ROX_ISOLATE = 2'b00,
      ROX_DRIVE_B = 2'b01,
      ROX_DRIVE_A = 2'b10
   } rox_mode_t;
endpackage : rox_pkg

// ==== design/rox_transceiver.sv ====
// registered octal bus transceiver with capture log fifo
`timescale 1ns/1ns

// ------------------------------------------------------------
// capture log fifo
// ------------------------------------------------------------
module rox_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : rox_fifo

// ------------------------------------------------------------
// transceiver top
// ------------------------------------------------------------
module rox_transceiver
   import rox_pkg::*;
#(
   parameter int DATA_W = ROX_DATA_W,
   parameter int LOG_DEPTH = ROX_LOG_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic output_enable_n,
   input wire logic direction_control,
   input wire logic a_to_b_clock,
   input wire logic b_to_a_clock,
   input wire logic a_to_b_source_select,
   input wire logic b_to_a_source_select,
   input wire logic [DATA_W-1:0] a_bus_in,
   output logic [DATA_W-1:0] a_bus_out,
   output logic a_bus_oe,
   input wire logic [DATA_W-1:0] b_bus_in,
   output logic [DATA_W-1:0] b_bus_out,
   output logic b_bus_oe,
   output logic [DATA_W-1:0] a_stored_register_value,
   output logic [DATA_W-1:0] b_stored_register_value,
   output logic [DATA_W:0] log_data,
   output logic log_valid,
   input wire logic log_ready,
   output logic log_accept
);
   // ------------------------------------------------------------
   // clock edge detection
   // ------------------------------------------------------------
   logic ab_prev;
   logic ba_prev;
   logic ab_rise;
   logic ba_rise;
   rox_mode_t mode;
   logic [DATA_W:0] log_in_data;
   logic log_in_valid;

   // prev starts high so a clock already high at release is no edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ab_prev <= ROX_CLK_PREV_RST;
         ba_prev <= ROX_CLK_PREV_RST;
      end else begin
         ab_prev <= a_to_b_clock;
         ba_prev <= b_to_a_clock;
      end
   end

   assign ab_rise = a_to_b_clock && !ab_prev;
   assign ba_rise = b_to_a_clock && !ba_prev;

   // ------------------------------------------------------------
   // storage registers
   // ------------------------------------------------------------
   // captures ignore mode so both stay live in every mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_stored_register_value <= DATA_W'(ROX_STORE_RST);
      end else if (ab_rise) begin
         a_stored_register_value <= a_bus_in;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         b_stored_register_value <= DATA_W'(ROX_STORE_RST);
      end else if (ba_rise) begin
         b_stored_register_value <= b_bus_in;
      end
   end

   // ------------------------------------------------------------
   // direction and output mux
   // ------------------------------------------------------------
   always_comb begin
      if (output_enable_n) begin
         mode = ROX_ISOLATE;
      end else if (direction_control) begin
         mode = ROX_DRIVE_B;
      end else begin
         mode = ROX_DRIVE_A;
      end
   end

   always_comb begin
      a_bus_oe = 1'b0;
      b_bus_oe = 1'b0;
      unique case (mode)
         ROX_ISOLATE: begin
         end
         ROX_DRIVE_B: b_bus_oe = 1'b1;
         ROX_DRIVE_A: a_bus_oe = 1'b1;
         default: begin
         end
      endcase
   end

   // live path is combinational, stored path follows the register
   assign b_bus_out = a_to_b_source_select ? a_stored_register_value : a_bus_in;
   assign a_bus_out = b_to_a_source_select ? b_stored_register_value : b_bus_in;

   // ------------------------------------------------------------
   // capture log
   // ------------------------------------------------------------
   // one record per cycle; if both clocks rise together A wins the log
   always_comb begin
      log_in_valid = ab_rise || ba_rise;
      log_in_data = '0;
      if (ab_rise) begin
         log_in_data = {ROX_SIDE_A, a_bus_in};
      end else if (ba_rise) begin
         log_in_data = {ROX_SIDE_B, b_bus_in};
      end
   end

   rox_fifo #(
      .WIDTH(DATA_W + 1),
      .DEPTH(LOG_DEPTH)
   ) u_log (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(log_in_data),
      .in_valid(log_in_valid),
      .in_ready(log_accept),
      .out_data(log_data),
      .out_valid(log_valid),
      .out_ready(log_ready)
   );
endmodule : rox_transceiver

// ==== test/rox_bus_agent.sv ====
// outside agents on both buses
`timescale 1ns/1ns
module rox_bus_agent (
   input wire logic [7:0] a_val, b_val, a_bus_out, b_bus_out,
   input wire logic a_bus_oe, b_bus_oe,
   output logic [7:0] a_bus_in, b_bus_in
);
   // agents let go of a bus the device drives, so the wire shows the device
   assign a_bus_in = a_bus_oe ? a_bus_out : a_val;
   assign b_bus_in = b_bus_oe ? b_bus_out : b_val;
endmodule : rox_bus_agent

// ==== test/rox_checker.sv ====
// concurrent checks on the transceiver pins
`timescale 1ns/1ns
module rox_checker
   import rox_pkg::*;
#(parameter int DATA_W = ROX_DATA_W) (
   input wire logic clk, rst_n, output_enable_n, direction_control,
   input wire logic a_to_b_clock, b_to_a_clock, a_bus_oe, b_bus_oe,
   input wire logic a_to_b_source_select, b_to_a_source_select,
   input wire logic [DATA_W-1:0] a_bus_in, a_bus_out, b_bus_in, b_bus_out,
   input wire logic [DATA_W-1:0] a_stored_register_value, b_stored_register_value
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a clock high across release is no edge
   sequence rise_a; $past(rst_n) && $rose(a_to_b_clock); endsequence
   sequence rise_b; $past(rst_n) && $rose(b_to_a_clock); endsequence
   a_iso_both_off: assert property (output_enable_n |-> !a_bus_oe && !b_bus_oe)
      else $error("bus driven in isolation");
   a_drive_b_only: assert property (!output_enable_n && direction_control
      |-> b_bus_oe && !a_bus_oe) else $error("b side not driven");
   a_drive_a_only: assert property (!output_enable_n && !direction_control
      |-> a_bus_oe && !b_bus_oe) else $error("a side not driven");
   a_live_to_b: assert property (b_bus_oe && !a_to_b_source_select
      |-> b_bus_out == a_bus_in) else $error("b not live");
   a_stored_to_b: assert property (b_bus_oe && a_to_b_source_select
      |-> b_bus_out == a_stored_register_value) else $error("b not stored");
   a_live_to_a: assert property (a_bus_oe && !b_to_a_source_select
      |-> a_bus_out == b_bus_in) else $error("a not live");
   a_stored_to_a: assert property (a_bus_oe && b_to_a_source_select
      |-> a_bus_out == b_stored_register_value) else $error("a not stored");
   a_capture_a: assert property (rise_a |=> a_stored_register_value == $past(a_bus_in))
      else $error("a capture wrong");
   a_capture_b: assert property (rise_b |=> b_stored_register_value == $past(b_bus_in))
      else $error("b capture wrong");
endmodule : rox_checker
bind rox_transceiver rox_checker #(.DATA_W(DATA_W)) chk_u (.*);

// ==== test/tb.sv ====
// self-checking bench for the transceiver
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
   typedef struct {logic [5:0] c; logic [7:0] av, bv; logic [1:0] oe; logic [7:0] ea, eb;} rox_row_t;
   logic clk = 0, rst_n = 0, output_enable_n = 1, direction_control = 0, log_ready = 0;
   logic a_to_b_clock = 0, b_to_a_clock = 0, a_to_b_source_select = 0, b_to_a_source_select = 0;
   logic a_bus_oe, b_bus_oe, log_valid, log_accept;
   logic [7:0] a_val = 8'h00, b_val = 8'h00, a_bus_in, b_bus_in, a_bus_out, b_bus_out;
   logic [7:0] a_stored_register_value, b_stored_register_value;
   logic [8:0] log_data;
   int bad_count = 0, n_checks = 0, k;
   // controls: enable_n, direction, a_to_b select, b_to_a select, a clock, b clock
   rox_row_t rows [8] = '{'{6'h23, 8'hA5, 8'h3C, 2'h0, 8'hA5, 8'h3C},
      '{6'h12, 8'h5A, 8'hC3, 2'h1, 8'h5A, 8'h3C}, '{6'h18, 8'h0F, 8'hC3, 2'h1, 8'h5A, 8'h3C},
      '{6'h1A, 8'h81, 8'hC3, 2'h1, 8'h81, 8'h3C}, '{6'h01, 8'h11, 8'h96, 2'h2, 8'h81, 8'h96},
      '{6'h05, 8'h11, 8'hE7, 2'h2, 8'h81, 8'hE7}, '{6'h04, 8'h11, 8'h42, 2'h2, 8'h81, 8'hE7},
      '{6'h3B, 8'h77, 8'h88, 2'h0, 8'h77, 8'h88}};
   rox_transceiver dut_u (.*);
   rox_bus_agent agent_u (.*);
   initial forever #10 clk = ~clk;
   task tick; @(posedge clk); #2; endtask : tick
   task pulse(input logic [1:0] p);
      {a_to_b_clock, b_to_a_clock} = p;
      tick;
      {a_to_b_clock, b_to_a_clock} = 2'h0;
      tick;
   endtask : pulse
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (3) tick;
      rst_n = 1;
      foreach (rows[i]) begin
         {output_enable_n, direction_control, a_to_b_source_select, b_to_a_source_select} = rows[i].c[5:2];
         a_val = rows[i].av;
         b_val = rows[i].bv;
         tick;
         pulse(rows[i].c[1:0]);
         `CHK("oe", rows[i].oe, {a_bus_oe, b_bus_oe})
         `CHK("a reg", rows[i].ea, a_stored_register_value)
         `CHK("b reg", rows[i].eb, b_stored_register_value)
         if (rows[i].oe[0]) `CHK("b bus", rows[i].c[3] ? rows[i].ea : a_val, b_bus_out)
         if (rows[i].oe[1]) `CHK("a bus", rows[i].c[2] ? rows[i].eb : b_val, a_bus_out)
      end
      // fill the log while its reader stalls
      k = 0;
      while (log_accept === 1'b1 && k < 20) begin
         pulse(2'h2);
         k++;
      end
      `CHK("fill", 10, k)
      a_val = 8'hC9;
      pulse(2'h2);
      `CHK("a reg full", 8'hC9, a_stored_register_value)
      `CHK("head", 9'h0A5, log_data)
      log_ready = 1'b1;
      k = 0;
      while (log_valid === 1'b1 && k < 20) begin
         tick;
         k++;
      end
      `CHK("drain", 16, k)
      output_enable_n = 1'b0;
      direction_control = 1'b1;
      rst_n = 1'b0;
      tick;
      `CHK("oe rst", 2'h1, {a_bus_oe, b_bus_oe})
      `CHK("reg rst", 16'h0000, {a_stored_register_value, b_stored_register_value})
      give_verdict();
   end
endmodule : tb
